/* File: logic/auto_reload_timer_control.sv */
// Control/status register and counting control of the auto-reload timer
//
// Overview of operation
// - High-byte overflow flag sets when high byte rolls from 0xff to its reload value.
// - In 16-bit mode the flag sets when the count wraps from 0xffff to the reload pair.
// - With timer interrupt enabled, a set high flag requests an interrupt.
// - Overflow flags are cleared only by software writes, never by hardware.
// - Low-byte overflow flag sets on every low-byte rollover, any mode.
// - Low-byte interrupt enable plus timer enable requests on low overflow.
// - Bit 4 enables capture mode when set, disables it when clear.
// - Split bit: 0 one 16-bit timer, 1 two 8-bit auto-reload timers.
// - Run control at bit 2 starts counting when 1, stops when 0.
// - In split mode run control gates only the high byte timer.
// - Bit 1 is unused: reads zero, writes ignored.
// - External select: 0 system clock/12, 1 synchronised external osc/8.
// - One external select serves both bytes; each byte picks its clock.
// - Control register at 0xc8, bit addressable, resets to zero.
// - Capture: osc/8 falling edge copies count to reload, sets high flag.
// - In 16-bit mode a wrap reloads the counter from the reload pair.
// - Byte clock-select 1 uses system clock, 0 the externally chosen one.
// - Software keeps 16-bit mode while capture mode is in use.
`timescale 1ns/100ps
module auto_reload_timer_control
    import timer_ctl_pkg::*;
(
    // Clock and reset
    input  wire logic       CLK,
    input  wire logic       RST_N,
    // Special-function register bus
    input  wire logic [7:0] SFR_ADDR,
    input  wire logic       SFR_WR,
    input  wire logic [7:0] SFR_WDATA,
    input  wire logic       SFR_BIT_WR,
    input  wire logic [2:0] SFR_BIT_SEL,
    input  wire logic       SFR_BIT_VAL,
    output logic      [7:0] SFR_RDATA,
    // Clock-select bits, interrupt enable and external oscillator from outside
    input  wire logic       HIGH_BYTE_CLOCK_SELECT,
    input  wire logic       LOW_BYTE_CLOCK_SELECT,
    input  wire logic       TIMER_IRQ_ENABLE,
    input  wire logic       EXT_OSC,
    // Reload writes from software
    input  wire logic       RELOAD_WR_LOW,
    input  wire logic       RELOAD_WR_HIGH,
    input  wire logic [7:0] RELOAD_WDATA,
    // Datapath view and interrupt
    output logic      [7:0] COUNT_LOW_BYTE,
    output logic      [7:0] COUNT_HIGH_BYTE,
    output logic      [7:0] RELOAD_LOW_BYTE,
    output logic      [7:0] RELOAD_HIGH_BYTE,
    output logic            TIMER_IRQ
);
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] cnt_lo;
        logic [7:0] cnt_hi;
        logic [7:0] rld_lo;
        logic [7:0] rld_hi;
        logic [3:0] presc;
        logic       irq;
    } timer_state_t;

    timer_state_t st_ff;
    timer_state_t nxt_st;
    logic         ext_tick;
    logic         ext_fall;

    ext_clk_capture_sync u_sync (
        .clk      (CLK),
        .rst_n    (RST_N),
        .ext_osc  (EXT_OSC),
        .ext_tick (ext_tick),
        .ext_fall (ext_fall)
    );

    // Byte clock: system clock or the externally chosen slow tick
    function automatic logic byte_tick(input logic sys_sel,
                                       input logic ext_sel,
                                       input logic sys12,
                                       input logic ext8);
        byte_tick = sys_sel ? 1'b1 : (ext_sel ? ext8 : sys12);
    endfunction

    logic ctrl_hit;
    logic sys12;
    logic tick_lo;
    logic tick_hi;
    logic split;
    logic run;
    logic lo_wrap;
    logic hi_wrap;
    logic capture;
    logic [7:0] wr_val;
    logic [7:0] cw;

    always_comb begin
        nxt_st   = st_ff;
        ctrl_hit = (SFR_ADDR == CTRL_ADDR);
        sys12    = (st_ff.presc == SYS_DIV_LAST);
        nxt_st.presc = sys12 ? 4'h0 : 4'(st_ff.presc + 4'h1);
        split    = st_ff.ctrl[SPLIT_BIT];
        run      = st_ff.ctrl[RUN_BIT];
        // One external select shared by both bytes
        tick_lo  = byte_tick(LOW_BYTE_CLOCK_SELECT,
                             st_ff.ctrl[EXT_CLK_BIT], sys12, ext_tick);
        tick_hi  = byte_tick(HIGH_BYTE_CLOCK_SELECT,
                             st_ff.ctrl[EXT_CLK_BIT], sys12, ext_tick);
        // Capture assumes 16-bit mode; split copies bytes as they stand
        capture  = st_ff.ctrl[CAPTURE_EN_BIT] && ext_fall;
        lo_wrap  = 1'b0;
        hi_wrap  = 1'b0;
        if (split) begin
            // Low byte free-running in split mode
            if (tick_lo) begin
                lo_wrap = (st_ff.cnt_lo == BYTE_MAX);
                nxt_st.cnt_lo = lo_wrap ? st_ff.rld_lo
                              : 8'(st_ff.cnt_lo + 8'h01);
            end
            if (run && tick_hi) begin
                hi_wrap = (st_ff.cnt_hi == BYTE_MAX);
                nxt_st.cnt_hi = hi_wrap ? st_ff.rld_hi
                              : 8'(st_ff.cnt_hi + 8'h01);
            end
        end else if (run && tick_lo) begin
            lo_wrap = (st_ff.cnt_lo == BYTE_MAX);
            hi_wrap = lo_wrap && (st_ff.cnt_hi == BYTE_MAX);
            if (hi_wrap) begin
                nxt_st.cnt_lo = st_ff.rld_lo;
                nxt_st.cnt_hi = st_ff.rld_hi;
            end else begin
                nxt_st.cnt_lo = 8'(st_ff.cnt_lo + 8'h01);
                if (lo_wrap) begin
                    nxt_st.cnt_hi = 8'(st_ff.cnt_hi + 8'h01);
                end
            end
        end
        // Software reload writes; a capture in the same cycle wins
        if (RELOAD_WR_LOW) begin
            nxt_st.rld_lo = RELOAD_WDATA;
        end
        if (RELOAD_WR_HIGH) begin
            nxt_st.rld_hi = RELOAD_WDATA;
        end
        if (capture) begin
            nxt_st.rld_lo = st_ff.cnt_lo;
            nxt_st.rld_hi = st_ff.cnt_hi;
        end
        // Register write: whole byte or single bit
        wr_val = st_ff.ctrl;
        if (ctrl_hit && SFR_WR) begin
            wr_val = SFR_WDATA;
        end else if (ctrl_hit && SFR_BIT_WR) begin
            wr_val[SFR_BIT_SEL] = SFR_BIT_VAL;
        end
        cw = (wr_val & CTRL_WMASK) | (st_ff.ctrl & ~CTRL_WMASK);
        // Hardware set beats a same-cycle software clear
        if (hi_wrap || capture) begin
            cw[HI_OVF_BIT] = 1'b1;
        end
        if (lo_wrap) begin
            cw[LO_OVF_BIT] = 1'b1;
        end
        cw[UNUSED_BIT] = 1'b0;
        nxt_st.ctrl = cw;
        // Level request while a flag stands and enables allow
        nxt_st.irq = TIMER_IRQ_ENABLE && (cw[HI_OVF_BIT] ||
                     (cw[LO_IRQ_EN_BIT] && cw[LO_OVF_BIT]));
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_ff      <= '0;
            st_ff.ctrl <= CTRL_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign SFR_RDATA        = ctrl_hit ? st_ff.ctrl : 8'h00;
    assign COUNT_LOW_BYTE   = st_ff.cnt_lo;
    assign COUNT_HIGH_BYTE  = st_ff.cnt_hi;
    assign RELOAD_LOW_BYTE  = st_ff.rld_lo;
    assign RELOAD_HIGH_BYTE = st_ff.rld_hi;
    assign TIMER_IRQ        = st_ff.irq;

    property p_hi_wrap_sets;
        @(posedge CLK) disable iff (!RST_N)
        hi_wrap |=> st_ff.ctrl[HI_OVF_BIT];
    endproperty
    a_hi_wrap_sets: assert property (p_hi_wrap_sets)
        else $error("high overflow did not set flag");

    property p_wide_wrap;
        @(posedge CLK) disable iff (!RST_N)
        (!split && run && tick_lo && st_ff.cnt_lo == 8'hff &&
         st_ff.cnt_hi == 8'hff) |=> st_ff.ctrl[HI_OVF_BIT] &&
        st_ff.cnt_lo == $past(st_ff.rld_lo) &&
        st_ff.cnt_hi == $past(st_ff.rld_hi);
    endproperty
    a_wide_wrap: assert property (p_wide_wrap)
        else $error("16-bit wrap did not reload and flag");

    property p_irq_high;
        @(posedge CLK) disable iff (!RST_N)
        (TIMER_IRQ_ENABLE && st_ff.ctrl[HI_OVF_BIT] &&
         $past(TIMER_IRQ_ENABLE)) |-> TIMER_IRQ;
    endproperty
    a_irq_high: assert property (p_irq_high)
        else $error("interrupt missing with high flag set");

    property p_no_hw_clear;
        @(posedge CLK) disable iff (!RST_N)
        ($past(st_ff.ctrl[LO_OVF_BIT]) && !st_ff.ctrl[LO_OVF_BIT])
        |-> $past(ctrl_hit && (SFR_WR || SFR_BIT_WR));
    endproperty
    a_no_hw_clear: assert property (p_no_hw_clear)
        else $error("low flag cleared without write");

    property p_no_hw_clear_hi;
        @(posedge CLK) disable iff (!RST_N)
        ($past(st_ff.ctrl[HI_OVF_BIT]) && !st_ff.ctrl[HI_OVF_BIT])
        |-> $past(ctrl_hit && (SFR_WR || SFR_BIT_WR));
    endproperty
    a_no_hw_clear_hi: assert property (p_no_hw_clear_hi)
        else $error("high flag cleared without write");

    property p_lo_wrap_sets;
        @(posedge CLK) disable iff (!RST_N)
        lo_wrap |=> st_ff.ctrl[LO_OVF_BIT];
    endproperty
    a_lo_wrap_sets: assert property (p_lo_wrap_sets)
        else $error("low overflow did not set flag");

    property p_unused_zero;
        @(posedge CLK) disable iff (!RST_N)
        !st_ff.ctrl[UNUSED_BIT];
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unused bit set");

    property p_stopped_hold;
        @(posedge CLK) disable iff (!RST_N)
        (!run && !capture) |=> st_ff.cnt_hi == $past(st_ff.cnt_hi);
    endproperty
    a_stopped_hold: assert property (p_stopped_hold)
        else $error("high byte moved while stopped");

    property p_capture_copy;
        @(posedge CLK) disable iff (!RST_N)
        capture |=> st_ff.rld_lo == $past(st_ff.cnt_lo) &&
        st_ff.ctrl[HI_OVF_BIT];
    endproperty
    a_capture_copy: assert property (p_capture_copy)
        else $error("capture did not copy count");

    property p_split_lo_runs;
        @(posedge CLK) disable iff (!RST_N)
        (split && LOW_BYTE_CLOCK_SELECT && st_ff.cnt_lo != 8'hff)
        |=> st_ff.cnt_lo == 8'($past(st_ff.cnt_lo) + 8'h01);
    endproperty
    a_split_lo_runs: assert property (p_split_lo_runs)
        else $error("split low byte not free running");
endmodule

/* File: logic/timer_ctl_pkg.sv */
// Package: register map, field positions and constants of the timer control
package timer_ctl_pkg;
    localparam logic [7:0] CTRL_ADDR       = 8'hc8;
    localparam logic [7:0] CTRL_RESET      = 8'h00;
    localparam int         HI_OVF_BIT      = 7;
    localparam int         LO_OVF_BIT      = 6;
    localparam int         LO_IRQ_EN_BIT   = 5;
    localparam int         CAPTURE_EN_BIT  = 4;
    localparam int         SPLIT_BIT       = 3;
    localparam int         RUN_BIT         = 2;
    localparam int         UNUSED_BIT      = 1;
    localparam int         EXT_CLK_BIT     = 0;
    localparam logic [7:0] CTRL_WMASK      = 8'hfd;
    localparam int         SYS_DIV         = 12;
    localparam int         EXT_DIV         = 8;
    localparam logic [7:0] BYTE_MAX        = 8'hff;
    localparam logic [3:0] SYS_DIV_LAST    = 4'(SYS_DIV - 1);
    localparam logic [2:0] EXT_DIV_LAST    = 3'(EXT_DIV - 1);
endpackage

/* File: logic/ext_clk_capture_sync.sv */
// External clock divide-by-8, synchroniser and falling-edge capture strobe
`timescale 1ns/100ps
module ext_clk_capture_sync
    import timer_ctl_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // External oscillator level, asynchronous
    input  wire logic ext_osc,
    // Divided-clock tick and falling-edge strobe, system domain
    output logic      ext_tick,
    output logic      ext_fall
);
    typedef struct packed {
        logic       sync1;
        logic       sync2;
        logic       prev;
        logic [2:0] div;
        logic       div_msb_prev;
        logic       tick;
        logic       fall;
    } sync_state_t;

    sync_state_t st_ff;
    sync_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.sync1 = ext_osc;
        // First stage feeds only the second
        nxt_st.sync2 = st_ff.sync1;
        nxt_st.prev  = st_ff.sync2;
        nxt_st.tick  = 1'b0;
        nxt_st.fall  = 1'b0;
        if (st_ff.sync2 && !st_ff.prev) begin
            nxt_st.div  = (st_ff.div == EXT_DIV_LAST) ? 3'h0
                        : 3'(st_ff.div + 3'h1);
            nxt_st.tick = (st_ff.div == EXT_DIV_LAST);
        end
        nxt_st.div_msb_prev = st_ff.div[2];
        // One strobe per falling edge of osc/8
        nxt_st.fall = st_ff.div_msb_prev && !st_ff.div[2];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign ext_tick = st_ff.tick;
    assign ext_fall = st_ff.fall;

    property p_fall_single;
        @(posedge clk) disable iff (!rst_n)
        ext_fall |=> !ext_fall;
    endproperty
    a_fall_single: assert property (p_fall_single)
        else $error("capture strobe longer than one cycle");
endmodule

/* File: verif/test_auto_reload_timer_control.sv */
// Self-checking bench for the auto-reload timer control block
`timescale 1ns/100ps
module test_auto_reload_timer_control;
    import timer_ctl_pkg::*;
    logic        clk, rst_n, wr_en, bit_wr, bit_val, hi_sel, lo_sel;
    logic        irq_en, ext_osc, rl_lo_wr, rl_hi_wr, irq, osc_on;
    logic [7:0]  addr, wdata, rdata, rl_data, c_lo, c_hi, r_lo, r_hi;
    logic [7:0]  model_ctrl, t0, rlo;
    logic [2:0]  bit_sel;
    logic [15:0] cap_a;
    int          num_errors, n_checks, osc_h, osc_cnt, d, n;

    auto_reload_timer_control u_dut (
        .CLK(clk), .RST_N(rst_n), .SFR_ADDR(addr), .SFR_WR(wr_en),
        .SFR_WDATA(wdata), .SFR_BIT_WR(bit_wr), .SFR_BIT_SEL(bit_sel),
        .SFR_BIT_VAL(bit_val), .SFR_RDATA(rdata),
        .HIGH_BYTE_CLOCK_SELECT(hi_sel), .LOW_BYTE_CLOCK_SELECT(lo_sel),
        .TIMER_IRQ_ENABLE(irq_en), .EXT_OSC(ext_osc),
        .RELOAD_WR_LOW(rl_lo_wr), .RELOAD_WR_HIGH(rl_hi_wr),
        .RELOAD_WDATA(rl_data), .COUNT_LOW_BYTE(c_lo),
        .COUNT_HIGH_BYTE(c_hi), .RELOAD_LOW_BYTE(r_lo),
        .RELOAD_HIGH_BYTE(r_hi), .TIMER_IRQ(irq));

    initial clk = 1'b0;
    always #5 clk = ~clk;

    // Oscillator made on the bench clock, so its period is exact in cycles
    always @(posedge clk) begin
        if (osc_on) begin
            if (osc_cnt == osc_h - 1) begin
                osc_cnt <= 0;
                ext_osc <= ~ext_osc;
            end else begin
                osc_cnt <= osc_cnt + 1;
            end
        end
    end

    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic step(int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] v);
        @(posedge clk);
        addr <= a; wdata <= v; wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0; addr <= CTRL_ADDR;
        if (a == CTRL_ADDR) model_ctrl = v & CTRL_WMASK;
        #1;
    endtask

    task automatic bw(int i, logic v);
        @(posedge clk);
        bit_wr <= 1'b1; bit_sel <= 3'(i); bit_val <= v;
        @(posedge clk);
        bit_wr <= 1'b0;
        if (i != UNUSED_BIT) model_ctrl[i] = v;
        #1;
    endtask

    task automatic rl(logic [7:0] lo, logic [7:0] hi);
        @(posedge clk);
        rl_lo_wr <= 1'b1; rl_data <= lo;
        @(posedge clk);
        rl_lo_wr <= 1'b0; rl_hi_wr <= 1'b1; rl_data <= hi;
        @(posedge clk);
        rl_hi_wr <= 1'b0;
        #1;
    endtask

    // Bounded wait for a control bit to read as one
    task automatic wait_bit(int b);
        d = 0;
        while (rdata[b] !== 1'b1 && d < 2000) begin
            step(1);
            d++;
        end
        check("flag wait", 16'(d < 2000), 16'h1);
    endtask

    function automatic logic near(logic [15:0] a, logic [15:0] e);
        return (a - e) <= 16'h1 || (a - e) == 16'hffff;
    endfunction

    initial begin
        #900000;
        num_errors++;
        conclude();
    end

    initial begin
        {rst_n, wr_en, bit_wr, bit_val, hi_sel, lo_sel} = '0;
        {irq_en, ext_osc, rl_lo_wr, rl_hi_wr, osc_on} = '0;
        {wdata, rl_data, bit_sel, osc_cnt, num_errors, n_checks} = '0;
        addr = CTRL_ADDR;
        model_ctrl = CTRL_RESET;
        osc_h = 2;
        void'($urandom(75));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        step(1);
        check("ctrl reset", rdata, CTRL_RESET);
        check("count reset", {c_hi, c_lo}, 16'h0);
        wr(8'hc9, 8'hff);
        check("other address", rdata, model_ctrl);
        wr(CTRL_ADDR, 8'hff);
        check("byte write", rdata, 8'hfd);
        wr(CTRL_ADDR, 8'h00);
        for (int i = 0; i < 8; i++) begin
            bw(i, 1'b1);
            check("bit set", rdata, model_ctrl);
            bw(i, 1'b0);
            check("bit clear", rdata, model_ctrl);
        end
        $display("test register finished");
        // Split mode, both bytes on the system clock
        hi_sel <= 1'b1;
        lo_sel <= 1'b1;
        rlo = 8'h80 + 8'($urandom_range(0, 111));
        rl(rlo, 8'($urandom_range(0, 200)));
        check("reload low", r_lo, rlo);
        t0 = c_hi;
        wr(CTRL_ADDR, 8'h08);
        wait_bit(LO_OVF_BIT);
        check("high held", c_hi, t0);
        check("high flag", rdata[HI_OVF_BIT], 1'b0);
        repeat (40) begin
            step(1);
            check("low reload", 16'(c_lo >= rlo), 16'h1);
        end
        irq_en <= 1'b1;
        step(2);
        check("irq low off", irq, 1'b0);
        bw(LO_IRQ_EN_BIT, 1'b1);
        step(1);
        check("irq low on", irq, 1'b1);
        bw(RUN_BIT, 1'b1);
        wait_bit(HI_OVF_BIT);
        // Starve both bytes of ticks so flags can only move by software
        hi_sel <= 1'b0;
        lo_sel <= 1'b0;
        wr(CTRL_ADDR, 8'hcd);
        step(30);
        check("flags kept", rdata, 8'hcd);
        irq_en <= 1'b0;
        step(2);
        check("irq masked", irq, 1'b0);
        wr(CTRL_ADDR, 8'h0d);
        step(30);
        check("flags clear", rdata, 8'h0d);
        $display("test split finished");
        // Clock sources: low byte on osc/8, high byte on system clock
        rl(8'h00, 8'h00);
        osc_h = $urandom_range(2, 5);
        osc_on <= 1'b1;
        hi_sel <= 1'b1;
        step(100);
        n = 192 * osc_h;
        cap_a = {c_hi, c_lo};
        step(n);
        // Reload of zero makes each byte count modulo 256
        check("ext rate", near(8'(c_lo - cap_a[7:0]), 12),
              1'b1);
        check("sys rate", 8'(c_hi - cap_a[15:8]), 8'(n));
        hi_sel <= 1'b0;
        wr(CTRL_ADDR, 8'h0c);
        cap_a = {c_hi, c_lo};
        step(240);
        check("div12 low", near(8'(c_lo - cap_a[7:0]), 20), 1'b1);
        check("div12 high", near(8'(c_hi - cap_a[15:8]), 20), 1'b1);
        $display("test clock finished");
        // 16-bit wrap with reload near the top
        hi_sel <= 1'b1;
        lo_sel <= 1'b1;
        rl(rlo, 8'hff);
        check("reload pair", {r_hi, r_lo}, {8'hff, rlo});
        step(300);
        irq_en <= 1'b1;
        wr(CTRL_ADDR, 8'h04);
        // High reload of 0xff wraps every cycle in split mode, so the
        // first write cannot clear the flag; clear it again in 16-bit mode
        wr(CTRL_ADDR, 8'h04);
        wait_bit(HI_OVF_BIT);
        check("low flag", rdata[LO_OVF_BIT], 1'b1);
        check("irq high", irq, 1'b1);
        repeat (20) begin
            step(1);
            check("wide reload",
                  16'({c_hi, c_lo} >= {8'hff, rlo}), 16'h1);
        end
        // Capture: successive captures one osc/8 period apart
        rl(8'h00, 8'h00);
        d = 0;
        while (c_hi === 8'hff && d < 600) begin
            step(1);
            d++;
        end
        wr(CTRL_ADDR, 8'h14);
        wait_bit(HI_OVF_BIT);
        cap_a = {r_hi, r_lo};
        wr(CTRL_ADDR, 8'h14);
        wait_bit(HI_OVF_BIT);
        check("capture gap", near({r_hi, r_lo} - cap_a, 16 * osc_h),
              1'b1);
        wr(CTRL_ADDR, 8'h04);
        cap_a = {r_hi, r_lo};
        t0 = c_lo;
        step(48 * osc_h);
        check("no capture", {r_hi, r_lo}, cap_a);
        // Window under 256 cycles: low flag only if the low byte wrapped;
        // a wrap on the clearing edge itself leaves the flag set
        check("no flag", rdata,
              {1'b0, 1'(c_lo < t0 || t0 == 8'h00), 6'h04});
        $display("test wide and capture finished");
        conclude();
    end
endmodule
